// File: shared/rxwb_pkg.sv
// rxwb_pkg: constants and carrier types for the receive status write-back.
// assumes a single bus clock domain; no imports, use rxwb_pkg::name.
package rxwb_pkg;

  // descriptor status word layout
  localparam int STAT_W = 32;
  localparam int LEN_W = 13;
  localparam int BIT_SUMMARY = 14;
  localparam int BIT_DONE = 15;
  localparam int BIT_OVERRUN = 16;
  localparam int BIT_SHORT = 17;
  localparam int BIT_ALIGN = 18;
  localparam int BIT_CHECKSUM = 19;
  localparam int BIT_TOOLONG = 20;
  localparam int BIT_TRAILING = 23;
  localparam int BIT_OVERFLOW = 24;
  localparam int BIT_INLINE = 28;

  // descriptor geometry and frame figures
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam logic [31:0] INLINE_BUF_OFFSET = 32'h0000_0008;
  localparam logic [15:0] INLINE_BUF_BYTES = 16'h05F8;
  localparam logic [12:0] SHORT_FRAME_BYTES = 13'h003C;
  localparam logic [12:0] FCS_BYTES = 13'h0004;
  localparam logic [15:0] LIMIT_RESET = 16'h05EE;

  // register offsets of the control port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0C;
  localparam logic [7:0] REG_INT_STATUS = 8'h10;
  localparam logic [7:0] REG_INT_CLEAR = 8'h14;
  localparam logic [7:0] REG_INT_ENABLE = 8'h18;

  // control and event bit positions
  localparam int CTRL_ENABLE = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_OVERFLOW = 2;
  localparam int EV_NOT_READY = 3;

  // raw conditions handed over by the receive path at frame end
  typedef struct packed {
    logic overrun;
    logic alignment;
    logic checksum;
    logic trailing;
    logic [LEN_W-1:0] len;
  } rxwb_mac_t;

  // evaluated per-frame flags
  typedef struct packed {
    logic overrun;
    logic shortFrame;
    logic alignment;
    logic checksum;
    logic tooLong;
    logic trailing;
    logic summary;
  } rxwb_flags_t;

  // host memory write request for the status word
  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [STAT_W-1:0] data;
  } rxwb_mem_wr_t;

endpackage

// File: hw/rxwb_frame_check.sv
// rxwb_frame_check: turns raw frame-end conditions into status flags.
// assumes frameEnd is a one-cycle pulse on mclk with frameInfo beside it.
`timescale 1ns/1ps
module rxwb_frame_check
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic frameEnd,
  input rxwb_pkg::rxwb_mac_t frameInfo,
  input wire logic [15:0] sizeLimit,
  output logic flagsValid,
  output rxwb_pkg::rxwb_flags_t flags
);

  typedef struct packed {
    logic valid;
    rxwb_pkg::rxwb_flags_t flags;
  } rxwb_chk_t;

  rxwb_chk_t s;
  rxwb_chk_t next_s;
  logic [12:0] bodyLen;

  // body length runs from destination address to end of payload
  assign bodyLen = frameInfo.len - rxwb_pkg::FCS_BYTES;

  // flags are held until the next frame end
  always_comb
  begin
    next_s = s;
    next_s.valid = frameEnd;
    if (frameEnd)
    begin
      next_s.flags.overrun = frameInfo.overrun; // see RULE1
      // a length below the fcs is short as well
      next_s.flags.shortFrame = (frameInfo.len < rxwb_pkg::FCS_BYTES) ||
        (bodyLen < rxwb_pkg::SHORT_FRAME_BYTES); // see RULE2
      next_s.flags.alignment = frameInfo.alignment; // see RULE3
      next_s.flags.checksum = frameInfo.checksum; // see RULE4
      next_s.flags.tooLong =
        ({3'h0, frameInfo.len} >= sizeLimit); // see RULE5
      // trailing bits stay out of the summary
      next_s.flags.trailing = frameInfo.trailing; // see RULE7
      next_s.flags.summary = frameInfo.overrun || frameInfo.alignment ||
        frameInfo.checksum || next_s.flags.shortFrame ||
        next_s.flags.tooLong; // see RULE15
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign flagsValid = s.valid;
  assign flags = s.flags;

endmodule // rxwb_frame_check

// File: hw/rxwb_status_writeback.sv
// rxwb_status_writeback: receive descriptor check, buffer-space policing
// and status word write-back with a small control port and interrupt.
// assumes the descriptor fetch, byte mover and memory writer sit on mclk.
//
// Contract
// RULE1 - set overrun flag bit 16 when receive buffer filled faster than drained
// RULE2 - set short frame flag bit 17 when body under 60 bytes
// RULE3 - set alignment fault flag bit 18 on alignment error
// RULE4 - set checksum fault flag bit 19 on frame check mismatch
// RULE5 - set too-long flag bit 20 when size reaches the limit
// RULE6 - error flags mean nothing until transfer-done reads one
// RULE7 - trailing extra bits reported at bit 23, never an error
// RULE8 - keep what fits, discard rest, set overflow bit 24
// RULE9 - inline enable gives one 1528-byte buffer at descriptor plus 0x08
// RULE10 - sample inline enable with the done check before receive DMA
// RULE11 - written value of inline enable bit is undefined
// RULE12 - host rewrites inline enable each time it hands descriptor back
// RULE13 - copy internal receive status to descriptor offset 0x04 at end
// RULE14 - set transfer-done bit 15 once frame is fully moved
// RULE15 - set summary error bit 14 on any of the five errors
// RULE16 - reserved positions 21-22, 25-27, 29-31 written as zero
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rxwb_status_writeback
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic descCheck,
  input wire logic [31:0] descAddr,
  input wire logic [31:0] descStatusWord,
  input wire logic [15:0] descFragBytes,
  output logic descAccept,
  output logic descReject,
  output logic bufInline,
  output logic [31:0] bufBase,
  output logic [15:0] bufBytes,
  input wire logic rxByteValid,
  output logic byteKeep,
  output logic byteDrop,
  input wire logic frameEnd,
  input rxwb_pkg::rxwb_mac_t frameInfo,
  output rxwb_pkg::rxwb_mem_wr_t wbReq,
  input wire logic wbAck,
  output logic irq
);

  typedef enum logic [1:0] {
    RXWB_IDLE,
    RXWB_RECV,
    RXWB_EVAL,
    RXWB_WRITE
  } rxwb_phase_t;

  typedef struct packed {
    rxwb_phase_t phase;
    logic enable;
    logic [15:0] limit;
    logic [31:0] rdData;
    logic accept;
    logic reject;
    logic inlineMode;
    logic [31:0] descBase;
    logic [31:0] base;
    logic [15:0] capacity;
    logic [15:0] moved;
    logic overflow;
    logic keep;
    logic drop;
    rxwb_pkg::rxwb_mac_t info;
    rxwb_pkg::rxwb_mem_wr_t wr;
    logic [31:0] lastWord;
    logic [rxwb_pkg::EV_W-1:0] intStatus;
    logic [rxwb_pkg::EV_W-1:0] intEnable;
    logic irq;
  } rxwb_state_t;

  rxwb_state_t s;
  rxwb_state_t next_s;
  logic chkValid;
  rxwb_pkg::rxwb_flags_t chkFlags;
  logic [rxwb_pkg::EV_W-1:0] events;
  logic [rxwb_pkg::STAT_W-1:0] statusWord;
  logic [6:0] regHit;

  // one decode serves both the write and the read side, so the two can
  // never disagree on which offset is which; unmapped gives no hit
  function automatic logic [6:0] reg_decode(input logic [7:0] a);
    logic [6:0] hit;
    hit = '0;
    if (a == rxwb_pkg::REG_CTRL)
      hit[0] = 1'h1;
    else if (a == rxwb_pkg::REG_LIMIT)
      hit[1] = 1'h1;
    else if (a == rxwb_pkg::REG_STATE)
      hit[2] = 1'h1;
    else if (a == rxwb_pkg::REG_LAST)
      hit[3] = 1'h1;
    else if (a == rxwb_pkg::REG_INT_STATUS)
      hit[4] = 1'h1;
    else if (a == rxwb_pkg::REG_INT_CLEAR)
      hit[5] = 1'h1;
    else if (a == rxwb_pkg::REG_INT_ENABLE)
      hit[6] = 1'h1;
    return hit;
  endfunction

  // register offset decode
  assign regHit = reg_decode(regAddr);

  // flag evaluation is registered, so write-back waits one cycle for it
  rxwb_frame_check u_check
  (
    .mclk(mclk),
    .rst(rst),
    .frameEnd(frameEnd && (s.phase == RXWB_RECV)),
    .frameInfo(frameInfo),
    .sizeLimit(s.limit),
    .flagsValid(chkValid),
    .flags(chkFlags)
  );

  // assemble the status word; every unnamed position stays zero
  always_comb
  begin
    statusWord = '0; // see RULE16
    statusWord[rxwb_pkg::LEN_W-1:0] = s.info.len;
    statusWord[rxwb_pkg::BIT_SUMMARY] = chkFlags.summary; // see RULE15
    statusWord[rxwb_pkg::BIT_DONE] = 1'h1; // see RULE14
    statusWord[rxwb_pkg::BIT_OVERRUN] = chkFlags.overrun; // see RULE1
    statusWord[rxwb_pkg::BIT_SHORT] = chkFlags.shortFrame; // see RULE2
    statusWord[rxwb_pkg::BIT_ALIGN] = chkFlags.alignment; // see RULE3
    statusWord[rxwb_pkg::BIT_CHECKSUM] = chkFlags.checksum; // see RULE4
    statusWord[rxwb_pkg::BIT_TOOLONG] = chkFlags.tooLong; // see RULE5
    statusWord[rxwb_pkg::BIT_TRAILING] = chkFlags.trailing; // see RULE7
    statusWord[rxwb_pkg::BIT_OVERFLOW] = s.overflow; // see RULE8
    // inline position is free to hold anything; zero is the cheapest
    statusWord[rxwb_pkg::BIT_INLINE] = 1'h0; // see RULE11
  end

  // main sequencing, byte policing, events and register port
  always_comb
  begin
    next_s = s;
    events = '0;
    next_s.accept = 1'h0;
    next_s.reject = 1'h0;
    next_s.keep = 1'h0;
    next_s.drop = 1'h0;
    next_s.rdData = '0;

    case (s.phase)
      RXWB_IDLE:
      begin
        if (descCheck && s.enable)
        begin
          // a done bit still set means the host has not handed it back
          if (descStatusWord[rxwb_pkg::BIT_DONE])
          begin
            next_s.reject = 1'h1;
            events[rxwb_pkg::EV_NOT_READY] = 1'h1;
          end
          else
          begin
            // inline enable sampled in the same check as the done bit
            next_s.accept = 1'h1;
            next_s.descBase = descAddr;
            next_s.inlineMode =
              descStatusWord[rxwb_pkg::BIT_INLINE]; // see RULE10
            next_s.moved = '0;
            next_s.overflow = 1'h0;
            if (descStatusWord[rxwb_pkg::BIT_INLINE])
            begin
              next_s.base = descAddr +
                rxwb_pkg::INLINE_BUF_OFFSET; // see RULE9
              next_s.capacity = rxwb_pkg::INLINE_BUF_BYTES; // see RULE9
            end
            else
            begin
              next_s.base = '0;
              next_s.capacity = descFragBytes;
            end
            next_s.phase = RXWB_RECV;
          end
        end
      end

      RXWB_RECV:
      begin
        // bytes past the buffer space are dropped, not stalled
        if (rxByteValid)
        begin
          if (s.moved < s.capacity)
          begin
            next_s.keep = 1'h1;
            next_s.moved = s.moved + 16'h0001;
          end
          else
          begin
            next_s.drop = 1'h1; // see RULE8
            next_s.overflow = 1'h1; // see RULE8
          end
        end
        if (frameEnd)
        begin
          next_s.info = frameInfo;
          next_s.phase = RXWB_EVAL;
        end
      end

      RXWB_EVAL:
      begin
        if (chkValid)
        begin
          // status lands at offset 0x04 of the descriptor
          next_s.wr.req = 1'h1;
          next_s.wr.addr = s.descBase +
            rxwb_pkg::STATUS_OFFSET; // see RULE13
          next_s.wr.data = statusWord; // see RULE13
          next_s.lastWord = statusWord;
          next_s.phase = RXWB_WRITE;
        end
      end

      RXWB_WRITE:
      begin
        // done and errors are announced together, only once written
        if (wbAck)
        begin
          next_s.wr.req = 1'h0;
          events[rxwb_pkg::EV_DONE] = 1'h1; // see RULE6
          events[rxwb_pkg::EV_ERROR] =
            s.wr.data[rxwb_pkg::BIT_SUMMARY]; // see RULE6
          events[rxwb_pkg::EV_OVERFLOW] =
            s.wr.data[rxwb_pkg::BIT_OVERFLOW];
          next_s.phase = RXWB_IDLE;
        end
      end

      default:
      begin
        next_s.phase = RXWB_IDLE;
      end
    endcase

    // register writes
    // unmapped and read-only offsets are ignored
    if (regWr)
    begin
      if (regHit[0])
      begin
        next_s.enable = regWrData[rxwb_pkg::CTRL_ENABLE];
      end
      else if (regHit[1])
      begin
        next_s.limit = regWrData[15:0];
      end
      else if (regHit[5])
      begin
        next_s.intStatus = s.intStatus & ~regWrData[rxwb_pkg::EV_W-1:0];
      end
      else if (regHit[6])
      begin
        next_s.intEnable = regWrData[rxwb_pkg::EV_W-1:0];
      end
    end

    // a new event wins over a clear in the same cycle
    next_s.intStatus = next_s.intStatus | events;

    // register reads; answer stands in the following cycle only
    if (regRd)
    begin
      if (regHit[0])
      begin
        next_s.rdData = {31'h0, s.enable};
      end
      else if (regHit[1])
      begin
        next_s.rdData = {16'h0, s.limit};
      end
      else if (regHit[2])
      begin
        next_s.rdData = {s.moved, 12'h0, s.overflow, s.inlineMode,
          s.phase};
      end
      else if (regHit[3])
      begin
        next_s.rdData = s.lastWord;
      end
      else if (regHit[4])
      begin
        next_s.rdData = {28'h0, s.intStatus};
      end
      else if (regHit[6])
      begin
        next_s.rdData = {28'h0, s.intEnable};
      end
      // unmapped and write-only offsets read as zero
      else
      begin
        next_s.rdData = '0;
      end
    end

    // level interrupt follows the registered status and enable
    next_s.irq = |(next_s.intStatus & next_s.intEnable);
  end

  // the whole block state registers here
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      // fields with a named reset value follow the blanket clear
      s <= '0;
      s.phase <= RXWB_IDLE;
      s.enable <= rxwb_pkg::CTRL_RESET;
      s.limit <= rxwb_pkg::LIMIT_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign regRdData = s.rdData;
  assign descAccept = s.accept;
  assign descReject = s.reject;
  assign bufInline = s.inlineMode;
  assign bufBase = s.base;
  assign bufBytes = s.capacity;
  assign byteKeep = s.keep;
  assign byteDrop = s.drop;
  assign wbReq = s.wr;
  assign irq = s.irq;

endmodule // rxwb_status_writeback

// File: tb/rxwb_chk_sva.sv
// rxwb_chk: port-level checks of descriptor check and status write-back.
// assumes one mclk domain with async active-high rst.
`timescale 1ns/1ps
module rxwb_chk
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic descCheck,
  input wire logic [31:0] descAddr,
  input wire logic [31:0] descStatusWord,
  input wire logic descAccept,
  input wire logic bufInline,
  input wire logic [31:0] bufBase,
  input wire logic [15:0] bufBytes,
  input wire logic byteDrop,
  input wire logic frameEnd,
  input rxwb_pkg::rxwb_mac_t frameInfo,
  input rxwb_pkg::rxwb_mem_wr_t wbReq,
  input wire logic wbAck
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_done_set:
    assert property (wbReq.req |-> wbReq.data[15])
    else $error("status written without done bit");
  chk_summary_any:
    assert property (wbReq.req |-> wbReq.data[14] == (|wbReq.data[20:16]))
    else $error("summary flag disagrees with error flags");
  chk_trailing_info:
    assert property (wbReq.req && wbReq.data[23] && !(|wbReq.data[20:16])
      |-> !wbReq.data[14])
    else $error("trailing bits marked as error");
  chk_short_len:
    assert property (wbReq.req |-> wbReq.data[17] ==
      (wbReq.data[12:0] < 13'h0040))
    else $error("short flag wrong for length");
  chk_reserved_zero:
    assert property (wbReq.req |-> wbReq.data[31:29] == 3'h0 &&
      wbReq.data[27:25] == 3'h0 && wbReq.data[22:21] == 2'h0)
    else $error("reserved status bits not zero");
  chk_copy_end:
    assert property (frameEnd |-> ##2 wbReq.req &&
      wbReq.data[12:0] == $past(frameInfo.len, 2))
    else $error("status not written two cycles after frame end");
  chk_req_hold:
    assert property (wbReq.req && !wbAck |=> wbReq.req &&
      $stable(wbReq.data) && $stable(wbReq.addr))
    else $error("write request changed before ack");
  chk_accept_cause:
    assert property (descAccept |-> $past(descCheck) &&
      !$past(descStatusWord[15]) && bufInline == $past(descStatusWord[28]))
    else $error("accept without a free descriptor check");
  chk_inline_buf:
    assert property (descAccept && bufInline |->
      bufBase == $past(descAddr) + 32'h0000_0008 && bufBytes == 16'h05F8)
    else $error("inline buffer base or size wrong");
  chk_drop_flag:
    assert property (byteDrop |-> ##[1:300] wbReq.req && wbReq.data[24])
    else $error("dropped byte without overflow flag");
endmodule // rxwb_chk

bind rxwb_status_writeback rxwb_chk chk_u
(
  .mclk(mclk),
  .rst(rst),
  .descCheck(descCheck),
  .descAddr(descAddr),
  .descStatusWord(descStatusWord),
  .descAccept(descAccept),
  .bufInline(bufInline),
  .bufBase(bufBase),
  .bufBytes(bufBytes),
  .byteDrop(byteDrop),
  .frameEnd(frameEnd),
  .frameInfo(frameInfo),
  .wbReq(wbReq),
  .wbAck(wbAck)
);

// File: tb/rxwb_host_mem.sv
// rxwb_host_mem: host memory side taking status word writes.
// assumes wbReq holds until acked; ackDelay makes the host slow.
`timescale 1ns/1ps
module rxwb_host_mem
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] ackDelay,
  input rxwb_pkg::rxwb_mem_wr_t wbReq,
  output logic wbAck,
  output logic [31:0] lastAddr,
  output logic [31:0] lastData
);
  logic [3:0] waitCnt;

  // one ack per write; word kept so the host reads it after done
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wbAck <= 1'h0;
      waitCnt <= 4'h0;
      lastAddr <= 32'h0;
      lastData <= 32'h0;
    end
    else if (wbReq.req && !wbAck && waitCnt == ackDelay)
    begin
      wbAck <= 1'h1;
      lastAddr <= wbReq.addr;
      lastData <= wbReq.data;
    end
    else
    begin
      wbAck <= 1'h0;
      waitCnt <= (wbReq.req && !wbAck) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule // rxwb_host_mem

// File: tb/rx_descriptor_status_writeback_tb.sv
// rx_descriptor_status_writeback_tb: directed tests of status write-back.
// assumes rxwb_host_mem acks writes and rxwb_chk is bound to the design.
`timescale 1ns/1ps
module rx_descriptor_status_writeback_tb;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic descCheck = 1'h0;
  logic [31:0] descAddr = 32'h0;
  logic [31:0] descStatusWord = 32'h0;
  logic [15:0] descFragBytes = 16'h0;
  logic rxByteValid = 1'h0;
  logic frameEnd = 1'h0;
  rxwb_pkg::rxwb_mac_t frameInfo = '0;
  logic [3:0] ackDelay = 4'h0;
  logic [31:0] regRdData, bufBase, lastAddr, lastData;
  logic [15:0] bufBytes;
  logic descAccept, descReject, bufInline, byteKeep, byteDrop, wbAck, irq;
  rxwb_pkg::rxwb_mem_wr_t wbReq;
  int err_count = 0;
  int n_checks = 0;
  int nKeep = 0;
  int nDrop = 0;

  always #20 mclk = ~mclk;

  rxwb_status_writeback dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .descCheck(descCheck), .descAddr(descAddr),
    .descStatusWord(descStatusWord), .descFragBytes(descFragBytes),
    .descAccept(descAccept), .descReject(descReject), .bufInline(bufInline),
    .bufBase(bufBase), .bufBytes(bufBytes), .rxByteValid(rxByteValid),
    .byteKeep(byteKeep), .byteDrop(byteDrop), .frameEnd(frameEnd),
    .frameInfo(frameInfo), .wbReq(wbReq), .wbAck(wbAck), .irq(irq));
  rxwb_host_mem host_u (.mclk(mclk), .rst(rst), .ackDelay(ackDelay),
    .wbReq(wbReq), .wbAck(wbAck), .lastAddr(lastAddr), .lastData(lastData));

  // byte verdicts counted as they come back
  always @(posedge mclk)
  begin
    nKeep <= nKeep + int'(byteKeep);
    nDrop <= nDrop + int'(byteDrop);
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string s, input logic [7:0] a, logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'h0;
    #1 chk(s, regRdData, e);
  endtask

  function automatic logic [31:0] stat(rxwb_pkg::rxwb_mac_t m, logic of,
      logic [15:0] lim);
    logic [31:0] s;
    s = {19'h0, m.len};
    s[16] = m.overrun;
    s[17] = m.len < 13'h0040;
    s[18] = m.alignment;
    s[19] = m.checksum;
    s[20] = {3'h0, m.len} >= lim;
    s[23] = m.trailing;
    s[24] = of;
    s[14] = |s[20:16];
    s[15] = 1'h1;
    return s;
  endfunction

  // one descriptor, n bytes, frame end, then the written word is judged
  task automatic frame(input logic inl, input logic [15:0] frag, input int n,
      input rxwb_pkg::rxwb_mac_t m, input logic [31:0] e);
    int i, k0, d0, cap;
    cap = inl ? 1528 : int'(frag);
    @(posedge mclk);
    descCheck <= 1'h1;
    descAddr <= 32'h0000_1000;
    descStatusWord <= {3'h0, inl, 28'h0};
    descFragBytes <= frag;
    @(posedge mclk);
    descCheck <= 1'h0;
    #1 chk("accept", descAccept, 1'h1);
    chk("inline", bufInline, inl);
    chk("base", bufBase, inl ? 32'h0000_1008 : 32'h0);
    chk("size", bufBytes, inl ? 16'h05F8 : frag);
    k0 = nKeep;
    d0 = nDrop;
    for (i = 0; i < n; i++)
    begin
      @(posedge mclk);
      rxByteValid <= 1'h1;
    end
    @(posedge mclk);
    rxByteValid <= 1'h0;
    frameEnd <= 1'h1;
    frameInfo <= m;
    @(posedge mclk);
    frameEnd <= 1'h0;
    for (i = 0; i < 40 && wbAck !== 1'h1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    chk("ack", wbAck, 1'h1);
    chk("done", lastData[15], 1'h1);
    chk("addr", lastAddr, 32'h0000_1004);
    chk("status", lastData & ~32'h1000_0000, e);
    @(posedge mclk);
    #1 chk("kept", nKeep - k0, (n < cap) ? n : cap);
    chk("dropped", nDrop - d0, (n > cap) ? n - cap : 0);
  endtask

  task automatic t_regs();
    rdchk("limit", 8'h04, 32'h0000_05EE);
    rdchk("ctrl", 8'h00, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(8'h00, 32'h0000_0001);
    wr(8'h18, 32'h0000_000F);
    $display("t_regs done");
  endtask

  // inline buffer, overrun and checksum, irq masked then cleared
  task automatic t_inline();
    frame(1'h1, 16'h0, 20, {4'hA, 13'h0064},
      stat({4'hA, 13'h0064}, 1'h0, 16'h05EE));
    @(posedge mclk);
    #1 chk("irq", irq, 1'h1);
    rdchk("events", 8'h10, 32'h0000_0003);
    wr(8'h18, 32'h0);
    @(posedge mclk);
    #1 chk("masked", irq, 1'h0);
    wr(8'h14, 32'h0000_000F);
    wr(8'h18, 32'h0000_000F);
    rdchk("cleared", 8'h10, 32'h0);
    $display("t_inline done");
  endtask

  // short frame with trailing bits into too small buffers, slow host
  task automatic t_overflow();
    ackDelay <= 4'h5;
    frame(1'h0, 16'h000A, 12, {4'h1, 13'h0014},
      stat({4'h1, 13'h0014}, 1'h1, 16'h05EE));
    rdchk("events", 8'h10, 32'h0000_0007);
    rdchk("state", 8'h08, 32'h000A_0008);
    wr(8'h14, 32'h0000_000F);
    ackDelay <= 4'h0;
    $display("t_overflow done");
  endtask

  // length equal to the limit, then one below it without errors
  task automatic t_limit();
    wr(8'h04, 32'h0000_0050);
    frame(1'h0, 16'h0100, 8, {4'h4, 13'h0050},
      stat({4'h4, 13'h0050}, 1'h0, 16'h0050));
    frame(1'h0, 16'h0100, 8, {4'h0, 13'h004F}, 32'h0000_804F);
    rdchk("last", 8'h0C, 32'h0000_804F);
    rdchk("events", 8'h10, 32'h0000_0003);
    wr(8'h14, 32'h0000_000F);
    $display("t_limit done");
  endtask

  // disabled block ignores a check; done bit still set is refused
  task automatic t_reject();
    wr(8'h00, 32'h0);
    @(posedge mclk);
    descCheck <= 1'h1;
    @(posedge mclk);
    descCheck <= 1'h0;
    #1 chk("ignored", {descReject, descAccept}, 2'h0);
    wr(8'h00, 32'h0000_0001);
    @(posedge mclk);
    descCheck <= 1'h1;
    descStatusWord <= 32'h0000_8000;
    @(posedge mclk);
    descCheck <= 1'h0;
    #1 chk("reject", {descReject, descAccept}, 2'h2);
    rdchk("events", 8'h10, 32'h0000_0008);
    $display("t_reject done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    t_regs();
    t_inline();
    t_overflow();
    t_limit();
    t_reject();
    finish_test();
  end

  // the tests take under two hundred cycles; this bounds a hang
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule // rx_descriptor_status_writeback_tb
